// file: design/isrep_core.sv
// Status reporting core: condition, event, summary byte and service request
//
// Overview of operation
// - Instrument condition bit 7 is set while any alarm is asserted.
// - Instrument condition bit 4 is set while a heater fault exists.
// - Condition bits 1 and 0 show sensor faults, one per input channel.
// - Status byte bit 3 is any bit of condition AND its enable mask.
// - Each instrument enable bit gates the same condition bit position.
// - Standard event bit 7 is set when operation completes.
// - Standard event bit 5 is set on a syntax error in a query.
// - Standard event bit 4 is set on a device error.
// - Standard event bit 3 is set when a valid command cannot execute.
// - Standard event bit 2 is set on a syntax error in a command.
// - Standard event bit 0 is set by reset to mark power-on; a read or clear-status empties it.
// - Status byte bit 5 is any bit of standard event AND its enable.
// - Status byte bit 6 is the request-for-service indication.
// - Status byte bit 4 is set while the output queue holds a message.
// - Service request goes out from status byte AND service enable mask.
// - Host writes and reads the service enable mask by command and query.
// - Clear-status clears events, the error queue and the message bit.
// - Event enable mask is set by command, read by query; one enables.
// - The standard event query returns the current event register.
// - Operation-complete command sets bit 7 once pending work finishes.
// - A one in the service enable mask enables that status bit.
`timescale 1ns/1ps

module isrep_core #(
    parameter int NUM_CHANNELS = 2
) (
    input wire logic ref_clk, // 100 MHz system clock
    input wire logic reset_n, // Asynchronous reset, active low
    // Command port from the command parser
    input wire logic cmd_valid, // Decoded command present, one-cycle pulse
    input wire isrep_pkg::isrep_cmd_t cmd_code, // Decoded command
    input wire logic [7:0] cmd_data, // Argument of set commands
    output logic rsp_valid, // Query answer present, one-cycle pulse
    output logic [7:0] rsp_data, // Query answer
    // Condition levels from the instrument (asynchronous)
    input wire logic alarm_active, // Any alarm asserted
    input wire logic heater_fault, // Heater fault present
    input wire logic [NUM_CHANNELS-1:0] sensor_fault, // Per-channel sensor fault
    // Event pulses from the command parser and the pending-work level (same clock)
    input wire logic query_syntax_error, // Syntax error in a query
    input wire logic device_fault_flag, // Device error
    input wire logic execution_failure, // Valid command that could not run
    input wire logic command_syntax_error, // Syntax error in a command
    input wire logic ops_pending, // Device operations still running
    // Output queue
    input wire logic message_waiting, // Output queue holds a message
    output logic output_queue_clear, // Flush output queue, one-cycle pulse
    output logic error_queue_clear, // Flush error queue, one-cycle pulse
    // Instrument bus
    output logic service_request, // Service request to the host
    output logic [7:0] status_byte // Current status summary byte
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    initial begin
        if (NUM_CHANNELS < 1 || NUM_CHANNELS > 2) begin
            $error("isrep_core: NUM_CHANNELS must be 1 or 2");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] event_reg;
        logic [7:0] event_en;
        logic [7:0] inst_en;
        logic [7:0] service_en;
        logic op_done_armed;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic service_request;
        logic [7:0] status_byte;
        logic oq_clear;
        logic eq_clear;
    } isrep_state_t;

    isrep_state_t state_q;
    isrep_state_t state_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic masked_any(input logic [7:0] value, input logic [7:0] mask);
        masked_any = |(value & mask);
    endfunction

    // ------------------------------------------------------------------
    // Condition inputs cross into the clock domain
    // ------------------------------------------------------------------
    localparam int COND_W = NUM_CHANNELS + 2;

    logic [COND_W-1:0] cond_sync;
    logic [7:0] inst_cond;
    logic [7:0] event_hits;
    logic [7:0] stb_now;
    logic event_summary_bit;
    logic instrument_summary_bit;
    logic service_request_flag;

    isrep_sync #(
        .WIDTH(COND_W)
    ) u_cond_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in({alarm_active, heater_fault, sensor_fault}),
        .sync_out(cond_sync)
    );

    // ------------------------------------------------------------------
    // Instrument condition and status byte
    // ------------------------------------------------------------------
    always_comb begin
        inst_cond = isrep_pkg::ZERO_BYTE;
        inst_cond[isrep_pkg::IC_ALARM_BIT] = cond_sync[COND_W-1];
        inst_cond[isrep_pkg::IC_HEATER_BIT] = cond_sync[COND_W-2];
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            inst_cond[isrep_pkg::IC_SENSOR_LSB + ch] = cond_sync[ch];
        end
    end

    // Bitwise gating, same position in mask and condition
    assign instrument_summary_bit = masked_any(inst_cond, state_q.inst_en);
    assign event_summary_bit = masked_any(state_q.event_reg, state_q.event_en);

    always_comb begin
        stb_now = isrep_pkg::ZERO_BYTE;
        stb_now[isrep_pkg::SB_EVENT_BIT] = event_summary_bit;
        stb_now[isrep_pkg::SB_MESSAGE_BIT] = message_waiting;
        stb_now[isrep_pkg::SB_INSTRUMENT_BIT] = instrument_summary_bit;
    end

    // Service bit itself is never in the enable mask, so no feedback loop
    assign service_request_flag = masked_any(stb_now, state_q.service_en);

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    always_comb begin
        event_hits = isrep_pkg::ZERO_BYTE;
        event_hits[isrep_pkg::EV_OP_DONE_BIT] = state_q.op_done_armed && !ops_pending;
        event_hits[isrep_pkg::EV_QUERY_ERR_BIT] = query_syntax_error;
        event_hits[isrep_pkg::EV_DEVICE_BIT] = device_fault_flag;
        event_hits[isrep_pkg::EV_EXEC_BIT] = execution_failure;
        event_hits[isrep_pkg::EV_CMD_ERR_BIT] = command_syntax_error;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.rsp_valid = 1'b0;
        state_d.oq_clear = 1'b0;
        state_d.eq_clear = 1'b0;

        // Completion fires once, then disarms
        if (state_q.op_done_armed && !ops_pending) begin
            state_d.op_done_armed = 1'b0;
        end

        if (cmd_valid) begin
            unique case (cmd_code)
                isrep_pkg::CMD_NONE: begin
                end
                isrep_pkg::CMD_CLEAR_STATUS: begin
                    state_d.event_reg = isrep_pkg::ZERO_BYTE;
                    state_d.op_done_armed = 1'b0;
                    state_d.oq_clear = 1'b1;
                    state_d.eq_clear = 1'b1;
                end
                isrep_pkg::CMD_SET_EVENT_EN: begin
                    state_d.event_en = cmd_data & isrep_pkg::EV_VALID_MASK;
                end
                isrep_pkg::CMD_GET_EVENT_EN: begin
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data = state_q.event_en;
                end
                isrep_pkg::CMD_GET_EVENT: begin
                    // Reading hands the events to the host and empties the register
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data = state_q.event_reg;
                    state_d.event_reg = isrep_pkg::ZERO_BYTE;
                end
                isrep_pkg::CMD_OP_COMPLETE: begin
                    state_d.op_done_armed = 1'b1;
                end
                isrep_pkg::CMD_SET_SERVICE_EN: begin
                    state_d.service_en = cmd_data & isrep_pkg::SB_ENABLE_MASK;
                end
                isrep_pkg::CMD_GET_SERVICE_EN: begin
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data = state_q.service_en;
                end
                isrep_pkg::CMD_GET_STATUS_BYTE: begin
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data = state_q.status_byte;
                end
                isrep_pkg::CMD_GET_INST_COND: begin
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data = inst_cond;
                end
                isrep_pkg::CMD_SET_INST_EN: begin
                    state_d.inst_en = cmd_data & isrep_pkg::IC_VALID_MASK;
                end
                isrep_pkg::CMD_GET_INST_EN: begin
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data = state_q.inst_en;
                end
                default: begin
                    state_d.eq_clear = 1'b0;
                end
            endcase
        end

        // New events win over a clear or a read in the same cycle
        state_d.event_reg = (state_d.event_reg | event_hits) & isrep_pkg::EV_VALID_MASK;

        state_d.status_byte = stb_now;
        state_d.status_byte[isrep_pkg::SB_SERVICE_BIT] = service_request_flag;
        state_d.service_request = service_request_flag;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.event_reg <= isrep_pkg::EV_RESET;
            state_q.event_en <= isrep_pkg::EV_EN_RESET;
            state_q.inst_en <= isrep_pkg::IC_EN_RESET;
            state_q.service_en <= isrep_pkg::SR_EN_RESET;
            state_q.op_done_armed <= 1'b0;
            state_q.rsp_valid <= 1'b0;
            state_q.rsp_data <= isrep_pkg::ZERO_BYTE;
            state_q.service_request <= 1'b0;
            state_q.status_byte <= isrep_pkg::ZERO_BYTE;
            state_q.oq_clear <= 1'b0;
            state_q.eq_clear <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rsp_valid = state_q.rsp_valid;
    assign rsp_data = state_q.rsp_data;
    assign output_queue_clear = state_q.oq_clear;
    assign error_queue_clear = state_q.eq_clear;
    assign service_request = state_q.service_request;
    assign status_byte = state_q.status_byte;

endmodule // isrep_core

// file: include/isrep_pkg.sv
// Constants, command codes and field layout for instrument status reporting
package isrep_pkg;

    // ------------------------------------------------------------------
    // Register width and bit positions
    // ------------------------------------------------------------------
    localparam int REG_W = 8;

    // Instrument condition register
    localparam int IC_ALARM_BIT = 7;
    localparam int IC_HEATER_BIT = 4;
    localparam int IC_SENSOR_LSB = 0;
    localparam logic [7:0] IC_VALID_MASK = 8'h93;

    // Standard event register
    localparam int EV_OP_DONE_BIT = 7;
    localparam int EV_QUERY_ERR_BIT = 5;
    localparam int EV_DEVICE_BIT = 4;
    localparam int EV_EXEC_BIT = 3;
    localparam int EV_CMD_ERR_BIT = 2;
    localparam int EV_POWER_BIT = 0;
    localparam logic [7:0] EV_VALID_MASK = 8'hbd;
    localparam logic [7:0] EV_RESET = 8'h01;

    // Status summary byte
    localparam int SB_SERVICE_BIT = 6;
    localparam int SB_EVENT_BIT = 5;
    localparam int SB_MESSAGE_BIT = 4;
    localparam int SB_INSTRUMENT_BIT = 3;
    localparam logic [7:0] SB_ENABLE_MASK = 8'h38;

    // Reset values of the enable masks
    localparam logic [7:0] IC_EN_RESET = 8'h00;
    localparam logic [7:0] EV_EN_RESET = 8'h00;
    localparam logic [7:0] SR_EN_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Decoded commands from the command parser
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_CLEAR_STATUS = 4'h1,
        CMD_SET_EVENT_EN = 4'h2,
        CMD_GET_EVENT_EN = 4'h3,
        CMD_GET_EVENT = 4'h4,
        CMD_OP_COMPLETE = 4'h5,
        CMD_SET_SERVICE_EN = 4'h6,
        CMD_GET_SERVICE_EN = 4'h7,
        CMD_GET_STATUS_BYTE = 4'h8,
        CMD_GET_INST_COND = 4'h9,
        CMD_SET_INST_EN = 4'ha,
        CMD_GET_INST_EN = 4'hb
    } isrep_cmd_t;

endpackage

// file: design/isrep_sync.sv
// Two-stage synchroniser for asynchronous condition levels
`timescale 1ns/1ps

module isrep_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } isrep_sync_t;

    isrep_sync_t state_q;
    isrep_sync_t state_d;

    initial begin
        if (WIDTH < 1) begin
            $error("isrep_sync: WIDTH must be at least 1");
        end
    end

    // First stage is read only by the second
    always_comb begin
        state_d = state_q;
        state_d.meta = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.stable;

endmodule // isrep_sync

// file: testbench/isrep_checker.sv
// Port-level checks for the status reporting core
`timescale 1ns/1ps
module isrep_checker #(
    parameter int NUM_CHANNELS = 2
) (
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic cmd_valid, // Command strobe
    input wire isrep_pkg::isrep_cmd_t cmd_code, // Command
    input wire logic [7:0] cmd_data, // Command argument
    input wire logic rsp_valid, // Answer strobe
    input wire logic [7:0] rsp_data, // Answer byte
    input wire logic alarm_active, // Alarm level
    input wire logic heater_fault, // Heater fault level
    input wire logic [NUM_CHANNELS-1:0] sensor_fault, // Sensor faults
    input wire logic query_syntax_error, // Event input
    input wire logic device_fault_flag, // Event input
    input wire logic execution_failure, // Event input
    input wire logic command_syntax_error, // Event input
    input wire logic ops_pending, // Work still running
    input wire logic message_waiting, // Output queue not empty
    input wire logic output_queue_clear, // Queue flush pulse
    input wire logic error_queue_clear, // Error flush pulse
    input wire logic service_request, // Request to host
    input wire logic [7:0] status_byte // Summary byte
);
    logic is_get;
    logic is_clr;
    assign is_get = cmd_valid && (cmd_code inside {isrep_pkg::CMD_GET_EVENT_EN, isrep_pkg::CMD_GET_EVENT,
        isrep_pkg::CMD_GET_SERVICE_EN, isrep_pkg::CMD_GET_STATUS_BYTE, isrep_pkg::CMD_GET_INST_COND,
        isrep_pkg::CMD_GET_INST_EN});
    assign is_clr = cmd_valid && (cmd_code == isrep_pkg::CMD_CLEAR_STATUS);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence s_opc_idle;
        (cmd_valid && cmd_code == isrep_pkg::CMD_OP_COMPLETE) ##1 (!cmd_valid && !ops_pending) [*3];
    endsequence
    sequence s_event_query;
        cmd_valid && cmd_code == isrep_pkg::CMD_GET_EVENT;
    endsequence
    a_sb_unused_zero: assert property (status_byte[7] == 1'b0 && status_byte[2:0] == 3'h0)
        else $error("status byte reserved bit set");
    a_msg_bit_follows: assert property ($past(reset_n) |-> status_byte[4] == $past(message_waiting))
        else $error("message bit does not follow queue");
    a_service_bit_mirror: assert property (status_byte[6] == service_request)
        else $error("service bit differs from request");
    a_service_needs_sum: assert property (status_byte[5:3] == 3'h0 |-> !service_request)
        else $error("service request without summary");
    a_clear_pulses: assert property (is_clr |=> output_queue_clear && error_queue_clear)
        else $error("clear status gave no flush");
    a_clear_cause: assert property (output_queue_clear || error_queue_clear |-> $past(is_clr))
        else $error("flush without clear status");
    a_query_answer: assert property (is_get |=> rsp_valid)
        else $error("query not answered");
    a_answer_cause: assert property (rsp_valid |-> $past(is_get))
        else $error("answer without query");
    a_opc_event_set: assert property (s_opc_idle ##1 s_event_query |=> rsp_valid && rsp_data[7])
        else $error("operation complete bit missing");
endmodule // isrep_checker
bind isrep_core isrep_checker #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .alarm_active(alarm_active), .heater_fault(heater_fault), .sensor_fault(sensor_fault),
    .query_syntax_error(query_syntax_error), .device_fault_flag(device_fault_flag),
    .execution_failure(execution_failure), .command_syntax_error(command_syntax_error),
    .ops_pending(ops_pending), .message_waiting(message_waiting), .output_queue_clear(output_queue_clear),
    .error_queue_clear(error_queue_clear), .service_request(service_request), .status_byte(status_byte));

// file: testbench/isrep_host.sv
// Host-side command source for the status reporting core
`timescale 1ns/1ps
module isrep_host (
    input wire logic ref_clk, // System clock
    output isrep_pkg::isrep_cmd_t cmd_code, // Command
    output logic cmd_valid, // Command strobe
    output logic [7:0] cmd_data, // Command argument
    input wire logic rsp_valid, // Answer strobe
    input wire logic [7:0] rsp_data // Answer byte
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = isrep_pkg::CMD_NONE;
        cmd_data = 8'h00;
    end
    // --------------------------------------------------------------
    // One command per call; argument inverted when idle
    // --------------------------------------------------------------
    task automatic issue(input isrep_pkg::isrep_cmd_t code, input logic [7:0] data, output logic [7:0] rsp);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_data = data;
        @(posedge ref_clk);
        #1;
        rsp = rsp_valid ? rsp_data : 8'hxx;
        cmd_valid = 1'b0;
        cmd_code = isrep_pkg::CMD_NONE;
        cmd_data = ~data;
    endtask
endmodule // isrep_host

// file: testbench/test_instrument_status_reporting.sv
// Self-checking bench for the status reporting core
`timescale 1ns/1ps
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module test_instrument_status_reporting;
    logic ref_clk = 1'b0, reset_n = 1'b0, alarm_active = 1'b0, heater_fault = 1'b0, ops_pending = 1'b0;
    logic message_waiting = 1'b0, cmd_valid, rsp_valid, service_request, sb3;
    logic [1:0] sensor_fault = 2'h0;
    logic [3:0] ev = 4'h0;
    logic [7:0] cmd_data, rsp_data, status_byte, r, m, c;
    isrep_pkg::isrep_cmd_t cmd_code;
    int err_count = 0, num_checks = 0, seed = 74885;
    int evb[4] = '{isrep_pkg::EV_QUERY_ERR_BIT, isrep_pkg::EV_DEVICE_BIT, isrep_pkg::EV_EXEC_BIT,
        isrep_pkg::EV_CMD_ERR_BIT};
    isrep_host host (.ref_clk(ref_clk), .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    isrep_core #(.NUM_CHANNELS(2)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .alarm_active(alarm_active), .heater_fault(heater_fault), .sensor_fault(sensor_fault),
        .query_syntax_error(ev[0]), .device_fault_flag(ev[1]), .execution_failure(ev[2]),
        .command_syntax_error(ev[3]), .ops_pending(ops_pending), .message_waiting(message_waiting),
        .output_queue_clear(), .error_queue_clear(), .service_request(service_request),
        .status_byte(status_byte));
    function automatic logic [7:0] exp_cond(input logic a, input logic h, input logic [1:0] s);
        return {a, 2'h0, h, 2'h0, s};
    endfunction
    task automatic run(input isrep_pkg::isrep_cmd_t code, input logic [7:0] d);
        host.issue(code, d, r);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input int i);
        tick(1);
        ev = 4'h1 << i;
        tick(1);
        ev = 4'h0;
    endtask
    task automatic finish_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        tick(5);
        reset_n = 1'b1;
        run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, isrep_pkg::EV_RESET)
        run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, 8'h00)
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 8'hff : 8'($random(seed));
            {alarm_active, heater_fault, sensor_fault} = (i == 0) ? 4'hf : 4'($random(seed));
            c = exp_cond(alarm_active, heater_fault, sensor_fault);
            run(isrep_pkg::CMD_SET_EVENT_EN, m);
            run(isrep_pkg::CMD_GET_EVENT_EN, 8'h00); `CHK(r, m & isrep_pkg::EV_VALID_MASK)
            run(isrep_pkg::CMD_SET_SERVICE_EN, m);
            run(isrep_pkg::CMD_GET_SERVICE_EN, 8'h00); `CHK(r, m & isrep_pkg::SB_ENABLE_MASK)
            run(isrep_pkg::CMD_SET_INST_EN, ~m);
            tick(4);
            run(isrep_pkg::CMD_GET_INST_COND, 8'h00); `CHK(r, c)
            run(isrep_pkg::CMD_GET_INST_EN, 8'h00); `CHK(r, ~m & isrep_pkg::IC_VALID_MASK)
            tick(2);
            sb3 = |(c & ~m);
            `CHK(status_byte[3], sb3)
            `CHK(service_request, m[3] & sb3)
        end
        {alarm_active, heater_fault, sensor_fault} = 4'h0;
        run(isrep_pkg::CMD_SET_SERVICE_EN, 8'h20);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            run(isrep_pkg::CMD_SET_EVENT_EN, ~(8'h01 << evb[i]));
            tick(2);
            `CHK(status_byte[5], 1'b0)
            run(isrep_pkg::CMD_SET_EVENT_EN, 8'h01 << evb[i]);
            tick(2);
            `CHK({service_request, status_byte[6:5]}, 3'h7)
            run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, 8'h01 << evb[i])
            tick(2);
            `CHK({service_request, status_byte[6:5]}, 3'h0)
        end
        run(isrep_pkg::CMD_SET_EVENT_EN, 8'h00);
        message_waiting = 1'b1;
        run(isrep_pkg::CMD_SET_SERVICE_EN, 8'h10);
        tick(2);
        `CHK({service_request, status_byte[4]}, 2'h3)
        run(isrep_pkg::CMD_GET_STATUS_BYTE, 8'h00); `CHK(r, 8'h50)
        run(isrep_pkg::CMD_NONE, 8'hff);
        run(isrep_pkg::CMD_GET_SERVICE_EN, 8'h00); `CHK(r, 8'h10)
        pulse(1);
        run(isrep_pkg::CMD_CLEAR_STATUS, 8'h00);
        run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, 8'h00)
        message_waiting = 1'b0;
        ops_pending = 1'b1;
        run(isrep_pkg::CMD_OP_COMPLETE, 8'h00);
        tick(3);
        run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, 8'h00)
        ops_pending = 1'b0;
        tick(4);
        run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, 8'h80)
        run(isrep_pkg::CMD_OP_COMPLETE, 8'h00);
        tick(2);
        run(isrep_pkg::CMD_GET_EVENT, 8'h00); `CHK(r, 8'h80)
        finish_test();
    end
endmodule // test_instrument_status_reporting
